// [logic/pixgam_defines.svh]
`ifndef PIXGAM_DEFINES_SVH
`define PIXGAM_DEFINES_SVH

// ****************************************
// command codes, byte view of the link
// ****************************************
`define CODE_ALL_BLACK    8'h22
`define CODE_ALL_WHITE    8'h23
`define CODE_GAMMA_SELECT 8'h26
`define CODE_NORMAL_ON    8'h13

// ****************************************
// curve select field
// ****************************************
`define CURVE_FIELD_MSB   3
`define CURVE_ONE         4'h1
`define CURVE_TWO         4'h2
`define CURVE_THREE       4'h4
`define CURVE_FOUR        4'h8
`define CURVE_RESET       4'h1

// ****************************************
// controller registers (byte addresses)
// ****************************************
`define ADDR_COMMAND      8'h00
`define ADDR_STATUS       8'h04
`define CMD_OP_LSB        0
`define CMD_OP_MSB        1
`define CMD_WIDE_BIT      4
`define CMD_PARAM_LSB     8
`define CMD_PARAM_MSB     15
`define STAT_BUSY_BIT     0
`define STAT_LAST_LSB     4
`define STAT_LAST_MSB     5

`endif

// [logic/pixgam_pkg.sv]
package pixgam_pkg;

  // operation that the controller is told to send
  typedef enum logic [1:0] {
    OP_NORMAL_ON,
    OP_ALL_BLACK,
    OP_ALL_WHITE,
    OP_GAMMA
  } host_op_t;

  // what the panel is made to show
  typedef enum logic [1:0] {
    PIX_IMAGE,
    PIX_BLACK,
    PIX_WHITE,
    PIX_BLANK
  } pix_mode_t;

  typedef enum logic {
    DEV_IDLE,
    DEV_WAIT_PARAM
  } dev_fsm_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_SEND_CMD,
    HOST_SEND_PARAM
  } host_fsm_t;

endpackage

// [logic/cmd_link_if.sv]
`timescale 1ns/1ns
interface cmd_link_if;
  logic        valid;
  logic        param;
  logic        wide;
  logic [15:0] data;

  modport host (
    output valid,
    output param,
    output wide,
    output data
  );

  modport device (
    input  valid,
    input  param,
    input  wide,
    input  data
  );
endinterface

// [logic/pixgam_device.sv]
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "pixgam_defines.svh"

module pixgam_device (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  cmd_link_if.device               link,
  input  wire logic                sw_reset_i,
  input  wire logic                sleep_out_i,
  input  wire logic                display_on_i,
  output logic                     black_active_o,
  output logic                     white_active_o,
  output logic [3:0]               curve_o,
  output pixgam_pkg::pix_mode_t    pix_mode_o,
  output logic                     curve_reject_o
);
  import pixgam_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dev_fsm_t   fsm;
    logic       black;
    logic       white;
    logic [3:0] curve;
    pix_mode_t  pix;
    logic       reject;
  } dev_state_t;

  // what one link word asks the decoder to do
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_BLACK,
    KIND_WHITE,
    KIND_NORMAL,
    KIND_GAMMA,
    KIND_PARAM,
    KIND_OTHER
  } word_kind_t;

  dev_state_t state;
  dev_state_t next_state;

  // ****************************************
  // helpers
  // ****************************************
  // a wide word carries its code in the high byte, a narrow one in the low byte
  function automatic logic [7:0] code_of(input logic wide, input logic [15:0] data);
    code_of = wide ? data[15:8] : data[7:0];
  endfunction

  function automatic logic curve_ok(input logic [3:0] v);
    curve_ok = (v == `CURVE_ONE) || (v == `CURVE_TWO) || (v == `CURVE_THREE) || (v == `CURVE_FOUR);
  endfunction

  // sorts one link word; a parameter counts only while a gamma command waits for it
  // a code that is not ours still reads as a command, so it ends a pending gamma
  function automatic word_kind_t kind_of(input logic       valid,
                                         input logic       param,
                                         input dev_fsm_t   fsm,
                                         input logic [7:0] code);
    if (!valid) begin
      kind_of = KIND_NONE;
    end else if (param) begin
      kind_of = (fsm == DEV_WAIT_PARAM) ? KIND_PARAM : KIND_NONE;
    end else begin
      unique case (code)
        `CODE_ALL_BLACK:    kind_of = KIND_BLACK;
        `CODE_ALL_WHITE:    kind_of = KIND_WHITE;
        `CODE_NORMAL_ON:    kind_of = KIND_NORMAL;
        `CODE_GAMMA_SELECT: kind_of = KIND_GAMMA;
        default:            kind_of = KIND_OTHER;
      endcase
    end
  endfunction

  // value that both resets leave; the panel mode is worked out afterwards
  function automatic dev_state_t cleared_state();
    cleared_state        = '0;
    cleared_state.fsm    = DEV_IDLE;
    cleared_state.black  = 1'b0;
    cleared_state.white  = 1'b0;
    cleared_state.curve  = `CURVE_RESET;
    cleared_state.pix    = PIX_BLANK;
    cleared_state.reject = 1'b0;
  endfunction

  // an override wins over display off, but sleep blanks the panel whatever is asked
  // display off alone blanks the panel only while no override is set
  function automatic pix_mode_t pix_of(input logic awake,
                                       input logic black,
                                       input logic white,
                                       input logic shown);
    if (!awake) begin
      pix_of = PIX_BLANK;
    end else if (black) begin
      pix_of = PIX_BLACK;
    end else if (white) begin
      pix_of = PIX_WHITE;
    end else if (shown) begin
      pix_of = PIX_IMAGE;
    end else begin
      pix_of = PIX_BLANK;
    end
  endfunction

  // decode intermediates, all filled at the top of the next-state process
  logic [7:0] code;
  logic [3:0] field;
  word_kind_t kind;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state        = state;
    next_state.reject = 1'b0;
    code              = code_of(link.wide, link.data);
    field             = link.data[`CURVE_FIELD_MSB:0];
    // no sleep qualifier on decoding: commands are taken in any power state
    kind = kind_of(link.valid, link.param, state.fsm, code);
    unique case (kind)
      KIND_BLACK: begin
        // setting an already set flag is the no-effect case
        next_state.fsm   = DEV_IDLE;
        next_state.black = 1'b1;
        next_state.white = 1'b0;
      end
      KIND_WHITE: begin
        next_state.fsm   = DEV_IDLE;
        next_state.white = 1'b1;
        next_state.black = 1'b0;
      end
      KIND_NORMAL: begin
        next_state.fsm   = DEV_IDLE;
        next_state.black = 1'b0;
        next_state.white = 1'b0;
      end
      KIND_GAMMA: begin
        next_state.fsm = DEV_WAIT_PARAM;
      end
      KIND_PARAM: begin
        // only the low nibble is looked at, the bits above are don't care
        next_state.fsm = DEV_IDLE;
        if (curve_ok(field)) begin
          next_state.curve = field;
        end else begin
          next_state.reject = 1'b1;
        end
      end
      KIND_OTHER: begin
        // other commands belong to other decoders; a pending gamma is dropped
        next_state.fsm = DEV_IDLE;
      end
      KIND_NONE: begin
        // idle link or a stray parameter: nothing moves
      end
    endcase
    if (sw_reset_i) begin
      // software reset wins over a word in the same cycle, reject pulse included
      next_state = cleared_state();
    end
    // the panel follows the flags as they will stand, so both move in one cycle
    next_state.pix = pix_of(sleep_out_i, next_state.black, next_state.white, display_on_i);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.fsm    <= DEV_IDLE;
      state.black  <= 1'b0;
      state.white  <= 1'b0;
      state.curve  <= `CURVE_RESET;
      state.pix    <= PIX_BLANK;
      state.reject <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a state flop, so nothing combinational reaches the pins
  assign black_active_o = state.black;
  assign white_active_o = state.white;
  assign curve_o        = state.curve;
  assign pix_mode_o     = state.pix;
  assign curve_reject_o = state.reject;
endmodule

// [logic/pixgam_host.sv]
`timescale 1ns/1ns
`include "pixgam_defines.svh"

module pixgam_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  cmd_link_if.host         link
);
  import pixgam_pkg::*;

  typedef struct packed {
    host_fsm_t   fsm;
    host_op_t    op;
    logic        wide;
    logic [7:0]  param;
    logic        ack;
    logic [31:0] rdata;
    logic        valid;
    logic        is_param;
    logic [15:0] data;
  } host_state_t;

  host_state_t state;
  host_state_t next_state;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] op_code(input host_op_t op);
    unique case (op)
      OP_NORMAL_ON: op_code = `CODE_NORMAL_ON;
      OP_ALL_BLACK: op_code = `CODE_ALL_BLACK;
      OP_ALL_WHITE: op_code = `CODE_ALL_WHITE;
      OP_GAMMA:     op_code = `CODE_GAMMA_SELECT;
    endcase
  endfunction

  // wide words put the byte high with a zero low byte, narrow ones put it low
  function automatic logic [15:0] word_of(input logic wide, input logic [7:0] b);
    word_of = wide ? {b, 8'h00} : {8'h00, b};
  endfunction

  logic req;
  logic launch;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state       = state;
    req              = wb_cyc_i && wb_stb_i && !state.ack;
    launch           = req && wb_we_i && (wb_adr_i == `ADDR_COMMAND) && wb_sel_i[0] && wb_sel_i[1]
                       && (state.fsm == HOST_IDLE);
    next_state.ack   = req;
    next_state.rdata = 32'h0000_0000;
    next_state.valid = 1'b0;
    if (req && !wb_we_i && wb_adr_i == `ADDR_STATUS) begin
      next_state.rdata[`STAT_BUSY_BIT]               = (state.fsm != HOST_IDLE);
      next_state.rdata[`STAT_LAST_MSB:`STAT_LAST_LSB] = state.op;
    end
    unique case (state.fsm)
      HOST_IDLE: begin
        if (launch) begin
          next_state.op    = host_op_t'(wb_dat_i[`CMD_OP_MSB:`CMD_OP_LSB]);
          next_state.wide  = wb_dat_i[`CMD_WIDE_BIT];
          next_state.param = wb_dat_i[`CMD_PARAM_MSB:`CMD_PARAM_LSB];
          next_state.fsm   = HOST_SEND_CMD;
        end
      end
      HOST_SEND_CMD: begin
        next_state.valid    = 1'b1;
        next_state.is_param = 1'b0;
        next_state.data     = word_of(state.wide, op_code(state.op));
        next_state.fsm      = (state.op == OP_GAMMA) ? HOST_SEND_PARAM : HOST_IDLE;
      end
      HOST_SEND_PARAM: begin
        // parameter always rides in the low byte, high byte zero
        next_state.valid    = 1'b1;
        next_state.is_param = 1'b1;
        next_state.data     = {8'h00, state.param};
        next_state.fsm      = HOST_IDLE;
      end
      default: begin
        next_state.fsm = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.fsm      <= HOST_IDLE;
      state.op       <= OP_NORMAL_ON;
      state.wide     <= 1'b0;
      state.param    <= 8'h00;
      state.ack      <= 1'b0;
      state.rdata    <= 32'h0000_0000;
      state.valid    <= 1'b0;
      state.is_param <= 1'b0;
      state.data     <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  assign wb_ack_o   = state.ack;
  assign wb_dat_o   = state.rdata;
  assign link.valid = state.valid;
  assign link.param = state.is_param;
  assign link.wide  = state.wide;
  assign link.data  = state.data;
endmodule

// [dv/pixgam_asserts.sv]
`timescale 1ns/1ns
// ****************
// link checker
// ****************
module pixgam_asserts (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  valid,
  input wire logic                  param,
  input wire logic                  wide,
  input wire logic [15:0]           data,
  input wire logic                  sw_reset_i,
  input wire logic                  sleep_out_i,
  input wire logic                  black_active_o,
  input wire logic                  white_active_o,
  input wire logic [3:0]            curve_o,
  input wire pixgam_pkg::pix_mode_t pix_mode_o,
  input wire logic                  curve_reject_o
);
  import pixgam_pkg::*;
  logic [7:0] code;
  logic       cmd;
  logic       gam;
  logic       par;
  // sw reset wins over a same-cycle word, so those cycles are left out
  assign code = wide ? data[15:8] : data[7:0];
  assign cmd  = valid && !param && !sw_reset_i;
  assign gam  = cmd && code == 8'h26;
  assign par  = valid && param && !sw_reset_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  black_set_a: assert property (cmd && code == 8'h22 |=> black_active_o && !white_active_o)
    else $error("black not set");
  white_set_a: assert property (cmd && code == 8'h23 |=> white_active_o && !black_active_o)
    else $error("white not set");
  normal_clear_a: assert property (cmd && code == 8'h13 |=> !black_active_o && !white_active_o)
    else $error("overrides kept");
  sw_clear_a: assert property (sw_reset_i |=> !black_active_o && !white_active_o && curve_o == 4'h1)
    else $error("sw reset ignored");
  override_excl_a: assert property (!(black_active_o && white_active_o))
    else $error("both overrides");
  curve_load_a: assert property (gam ##1 par && $onehot(data[3:0])
    |=> curve_o == $past(data[3:0])) else $error("curve not loaded");
  curve_keep_a: assert property (gam ##1 par && !$onehot(data[3:0])
    |=> curve_reject_o && $stable(curve_o)) else $error("bad curve taken");
  pix_black_a: assert property (black_active_o && $past(sleep_out_i) && !$past(rst_i)
    |-> pix_mode_o == PIX_BLACK) else $error("black not shown");
  pix_white_a: assert property (white_active_o && $past(sleep_out_i) && !$past(rst_i)
    |-> pix_mode_o == PIX_WHITE) else $error("white not shown");
  pix_sleep_a: assert property (!$past(sleep_out_i) && !$past(rst_i) |-> pix_mode_o == PIX_BLANK)
    else $error("sleep not blank");
endmodule

// [dv/all_pixel_and_gamma_commands_tb.sv]
`timescale 1ns/1ns
module all_pixel_and_gamma_commands_tb;
  import pixgam_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, sw_reset, sleep_out, display_on, black, white, reject;
  logic [7:0]  adr;
  logic [3:0]  sel, curve;
  logic [31:0] dat_w, dat_r, rd;
  pix_mode_t   pix;
  int          n_fail, n_checks;
  cmd_link_if link ();
  pixgam_host i_pixgam_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel), .wb_dat_o(dat_r), .wb_ack_o(ack), .link(link));
  pixgam_device i_pixgam_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .sw_reset_i(sw_reset),
    .sleep_out_i(sleep_out), .display_on_i(display_on), .black_active_o(black), .white_active_o(white),
    .curve_o(curve), .pix_mode_o(pix), .curve_reject_o(reject));
  pixgam_asserts i_pixgam_asserts (.clk_i(clk_i), .rst_i(rst_i), .valid(link.valid), .param(link.param),
    .wide(link.wide), .data(link.data), .sw_reset_i(sw_reset), .sleep_out_i(sleep_out), .black_active_o(black),
    .white_active_o(white), .curve_o(curve), .pix_mode_o(pix), .curve_reject_o(reject));
  // ****************
  // helpers
  // ****************
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      n_fail++;
      conclude();
    end
  endtask
  // busy is polled so the next order never lands while a word is in flight
  task automatic send(input logic [1:0] op, input logic w, input logic [7:0] p);
    int i;
    wb(1'b1, 8'h00, {16'h0000, p, 3'b000, w, 2'b00, op});
    for (i = 0; i < 20; i++) begin
      wb(1'b0, 8'h04, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      conclude();
    end
    check("last op", {30'h0, op}, {30'h0, rd[5:4]});
    @(negedge clk_i);
  endtask
  task automatic flags(input logic b, input logic wt, input pix_mode_t m);
    check("black", b, black);
    check("white", wt, white);
    check("pix", m, pix);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic scen_reset();
    @(negedge clk_i);
    flags(1'b0, 1'b0, PIX_BLANK);
    check("curve", 4'h1, curve);
    wb(1'b0, 8'h08, 32'h0);
    check("unmapped", 32'h0, rd);
  endtask
  task automatic scen_overrides();
    send(OP_ALL_BLACK, 1'b0, 8'h00);
    flags(1'b1, 1'b0, PIX_BLACK);
    send(OP_ALL_BLACK, 1'b1, 8'h00);
    flags(1'b1, 1'b0, PIX_BLACK);
    send(OP_ALL_WHITE, 1'b1, 8'h00);
    flags(1'b0, 1'b1, PIX_WHITE);
    send(OP_ALL_WHITE, 1'b0, 8'h00);
    flags(1'b0, 1'b1, PIX_WHITE);
    send(OP_ALL_BLACK, 1'b0, 8'h00);
    flags(1'b1, 1'b0, PIX_BLACK);
    @(posedge clk_i);
    display_on <= 1'b1;
    send(OP_ALL_WHITE, 1'b1, 8'h00);
    send(OP_NORMAL_ON, 1'b1, 8'h00);
    flags(1'b0, 1'b0, PIX_IMAGE);
    check("curve", 4'h1, curve);
  endtask
  task automatic scen_gamma();
    logic [3:0] v [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
    for (int i = 0; i < 4; i++) begin
      send(OP_GAMMA, i[0], {4'h0, v[i]});
      check("curve", v[i], curve);
    end
    send(OP_GAMMA, 1'b0, 8'hF4);
    check("curve", 4'h4, curve);
    send(OP_GAMMA, 1'b1, 8'h03);
    check("curve", 4'h4, curve);
    send(OP_GAMMA, 1'b0, 8'h00);
    check("curve", 4'h4, curve);
  endtask
  task automatic scen_sleep();
    @(posedge clk_i);
    sleep_out <= 1'b0;
    send(OP_ALL_WHITE, 1'b0, 8'h00);
    flags(1'b0, 1'b1, PIX_BLANK);
    send(OP_GAMMA, 1'b1, 8'h02);
    check("curve", 4'h2, curve);
    send(OP_ALL_BLACK, 1'b1, 8'h00);
    @(posedge clk_i);
    sleep_out <= 1'b1;
    repeat (2) @(negedge clk_i);
    flags(1'b1, 1'b0, PIX_BLACK);
  endtask
  task automatic scen_resets();
    send(OP_ALL_WHITE, 1'b0, 8'h00);
    @(posedge clk_i);
    sw_reset <= 1'b1;
    @(posedge clk_i);
    sw_reset <= 1'b0;
    repeat (2) @(negedge clk_i);
    flags(1'b0, 1'b0, PIX_IMAGE);
    check("curve", 4'h1, curve);
    send(OP_ALL_BLACK, 1'b0, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    flags(1'b0, 1'b0, PIX_BLANK);
    @(posedge clk_i);
    display_on <= 1'b0;
    @(negedge clk_i);
    flags(1'b0, 1'b0, PIX_IMAGE);
    @(negedge clk_i);
    flags(1'b0, 1'b0, PIX_BLANK);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cyc, stb, we, adr, dat_w, sel, sw_reset, display_on} = '0;
    rst_i = 1'b1;
    sleep_out = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    scen_reset();
    scen_overrides();
    scen_gamma();
    scen_sleep();
    scen_resets();
    conclude();
  end
endmodule
